// ---- rtl/pd_ctrl_pkg.sv ----
/*
 * Constants, register map and carrier types for the power-down controller
 * that drives a DDR3 device's CKE and command pins.
 * Assumes a 200 MHz pclk that also serves as the memory clock CK.
 */
// What this block does
// - Halve refresh interval above 85C
// - No self refresh hot without an option
// - MR2 bit 7 picks temperature range
// - Range bit zero whenever auto set
// - Keep CKE high during MRS/ZQ/READ/WRITE
// - Wait 1 clock or tMOD before CKE low
// - Read/write to CKE low minimum delays
// - Write-autoprecharge to CKE low delay
// - Refresh in power-down: wait tXPDLL
// - Only NOP until buffers disabled
// - Reset DLL if entered unlocked
// - Hold CKE low, reset high inside
// - Minimum and maximum power-down time
// - CKE high with NOP exits, hold tCKE
// - Slow exit: tXPDLL before reads
// - Exit-refresh-entry spacing rules
package pd_ctrl_pkg;

	// ----------------------------------------------------------------
	// Clock and time figures
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int TXPDLL_MIN_PS   = 24000;
	localparam int TXPDLL_MIN_TCK  = 10;
	localparam int TXPDLL_CYC      = ((TXPDLL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
	                                  > TXPDLL_MIN_TCK) ?
	                                  (TXPDLL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS :
	                                  TXPDLL_MIN_TCK;
	localparam int TREFI_64_NS     = 7800;
	localparam int TREFI_CYC       = TREFI_64_NS * 1000 / CLK_PERIOD_PS;
	localparam int PD_MAX_REFI     = 9;
	localparam int ACT_PD_CYC      = 1;
	localparam int CNT_W           = 16;

	// ----------------------------------------------------------------
	// APB register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_TIMING = 8'h04;
	localparam logic [7:0]  REG_CMD    = 8'h08;
	localparam logic [7:0]  REG_STATUS = 8'h0c;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] TIMING_RST = 32'h0604_0c05;

	// CTRL bit positions
	localparam int CTRL_AUTO_SR  = 0;
	localparam int CTRL_SR_RANGE = 1;
	localparam int CTRL_FAST   = 2;
	localparam int CTRL_HOT    = 3;
	localparam int CTRL_BC4MRS = 4;

	// DDR3 command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_MRS = 4'h0;

	// Software command codes written to REG_CMD[3:0]
	typedef enum logic [3:0] {
		OP_ACT = 4'h1, OP_RD = 4'h2, OP_WR = 4'h3, OP_WRAP = 4'h4,
		OP_PRE = 4'h5, OP_REF = 4'h6, OP_MRS = 4'h7, OP_PDE = 4'h8,
		OP_PDX = 4'h9, OP_DLLRST = 4'ha
	} op_e;

	// Pin bundle toward the memory
	typedef struct packed {
		logic       cke;
		logic       reset_n;
		logic [3:0] cmd;
		logic       a12;
	} dram_pins_s;

	// Timing fields from REG_TIMING
	typedef struct packed {
		logic [7:0] tmod;
		logic [7:0] wr;
		logic [7:0] rl;
		logic [7:0] wl;
	} timing_s;

endpackage

// ---- rtl/pd_down_counter.sv ----
/*
 * Loadable down-counter used for every minimum interval.
 * Assumes loads come from logic on the same clock.
 */
`timescale 1ns/1ps
module pd_down_counter #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	// Status
	output logic              done
);
	import pd_ctrl_pkg::*;

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Next count: load wins, else count to zero and stop
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = value;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == '0);
endmodule

// ---- rtl/pd_ctrl.sv ----
/*
 * Host-side power-down controller: software orders commands over APB,
 * the block spaces them on the DDR3 pins and enforces power-down timing.
 * Assumes pclk is the memory clock; the device answers nothing back.
 */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module pd_ctrl (
	// APB slave
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Memory pins
	output pd_ctrl_pkg::dram_pins_s       dram,
	output logic                          auto_self_refresh,
	output logic                          self_refresh_temp_range,
	output logic                          mr0_fast_exit
);
	import pd_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_PD     = 2'b01,
		ST_EXIT   = 2'b11
	} pd_state_e;

	pd_state_e  state_q, state_d;
	logic [31:0] ctrl_q, ctrl_d;
	timing_s    tim_q, tim_d;
	dram_pins_s pins_q, pins_d;
	logic [31:0] prdata_q, prdata_d;
	logic       pready_q, pready_d, pslverr_q, pslverr_d;
	logic       busy_q, busy_d;      // CKE-high-only op running
	logic       bank_open_q, bank_open_d;
	logic       dll_rst_need_q, dll_rst_need_d;
	logic       slow_q, slow_d;      // last entry was slow-exit precharge PD
	logic       refresh_in_pd_q, refresh_in_pd_d;
	logic       err_q, err_d;        // sticky fault: refresh in power-down or hot without option
	logic [CNT_W-1:0] pd_time_q, pd_time_d;
	logic       overdue_q, overdue_d;

	// Counter controls
	logic             pden_load, cmd_load, lock_load, xp_load, busy_load;
	logic [CNT_W-1:0] pden_val, cmd_val, busy_val;
	logic             pden_ok, cmd_ok, lock_ok, xp_ok, busy_done;

	// ----------------------------------------------------------------
	// Interval counters
	// ----------------------------------------------------------------
	pd_down_counter #(.W(CNT_W)) u_pden (.pclk(pclk), .presetn(presetn),
		.load(pden_load), .value(pden_val), .done(pden_ok));
	pd_down_counter #(.W(CNT_W)) u_cmd (.pclk(pclk), .presetn(presetn),
		.load(cmd_load), .value(cmd_val), .done(cmd_ok));
	pd_down_counter #(.W(CNT_W)) u_lock (.pclk(pclk), .presetn(presetn),
		.load(lock_load), .value(CNT_W'(TXPDLL_CYC)), .done(lock_ok));
	pd_down_counter #(.W(CNT_W)) u_xp (.pclk(pclk), .presetn(presetn),
		.load(xp_load), .value(CNT_W'(ACT_PD_CYC + 2)), .done(xp_ok));
	pd_down_counter #(.W(CNT_W)) u_busy (.pclk(pclk), .presetn(presetn),
		.load(busy_load), .value(busy_val), .done(busy_done));

	// Widen an 8-bit timing field
	function automatic logic [CNT_W-1:0] wid(input logic [7:0] v);
		return {{(CNT_W-8){1'b0}}, v};
	endfunction

	// ----------------------------------------------------------------
	// APB decode and command sequencing
	// ----------------------------------------------------------------
	logic       wr_acc, rd_acc;
	logic [3:0] op;
	logic       sr_mode_ok;

	always_comb begin
		wr_acc = psel && penable && pwrite && !pready_q;
		rd_acc = psel && penable && !pwrite && !pready_q;
		op     = pwdata[3:0];
		state_d = state_q;
		ctrl_d = ctrl_q;
		tim_d = tim_q;
		pins_d = pins_q;
		pins_d.cmd = CMD_NOP;        // Commands are one-cycle pulses
		pins_d.a12 = 1'b1;
		pins_d.reset_n = 1'b1;
		prdata_d = prdata_q;
		pready_d = psel && penable && !pready_q;
		pslverr_d = 1'b0;
		busy_d = busy_q && !busy_done;
		bank_open_d = bank_open_q;
		dll_rst_need_d = dll_rst_need_q;
		slow_d = slow_q;
		refresh_in_pd_d = refresh_in_pd_q;
		err_d = err_q;
		pd_time_d = pd_time_q;
		overdue_d = overdue_q;
		pden_load = 1'b0;
		pden_val = '0;
		cmd_load = 1'b0;
		cmd_val = '0;
		lock_load = 1'b0;
		xp_load = 1'b0;
		busy_load = 1'b0;
		busy_val = '0;
		// Both bits set is illegal; write refused below
		sr_mode_ok = !(pwdata[CTRL_AUTO_SR] && pwdata[CTRL_SR_RANGE]);

		// Power-down residency versus nine refresh intervals
		if (state_q == ST_PD) begin
			if (pd_time_q != '1) begin
				pd_time_d = pd_time_q + 1'b1;
			end
			// Hot case halves the interval
			if ((ctrl_q[CTRL_HOT] &&
			     pd_time_q >= CNT_W'(PD_MAX_REFI * TREFI_CYC / 2)) ||
			    pd_time_q >= CNT_W'(PD_MAX_REFI * TREFI_CYC / 2) * 2'd2) begin
				overdue_d = 1'b1;
			end
		end

		if (state_q == ST_EXIT && xp_ok) begin
			state_d = ST_ACTIVE;
		end

		if (wr_acc) begin
			unique case (paddr)
				REG_CTRL: begin
					if (sr_mode_ok) begin
						ctrl_d = pwdata;
					end else begin
						pslverr_d = 1'b1;
					end
				end
				REG_TIMING: tim_d = timing_s'(pwdata);
				REG_CMD: begin
					// Only NOP while buffer disable delay runs; cke low also after reset
					if ((!pins_q.cke && op != OP_PDX && op != OP_REF) ||
					    !cmd_ok) begin
						pslverr_d = 1'b1;
					end else begin
						unique case (op)
							OP_ACT, OP_PRE: begin
								pins_d.cmd = (op == OP_ACT) ? CMD_ACT : CMD_PRE;
								bank_open_d = (op == OP_ACT);
								pden_load = 1'b1;
								pden_val = CNT_W'(ACT_PD_CYC);
							end
							OP_RD: begin
								if (!lock_ok || dll_rst_need_q) begin
									pslverr_d = 1'b1;
								end else begin
									pins_d.cmd = CMD_RD;
									busy_load = 1'b1;
									busy_val = wid(tim_q.rl) + CNT_W'(5);
									pden_load = 1'b1;
									pden_val = wid(tim_q.rl) + CNT_W'(5);
								end
							end
							OP_WR, OP_WRAP: begin
								pins_d.cmd = CMD_WR;
								busy_load = 1'b1;
								pden_load = 1'b1;
								// Fixed chop-of-four ends two clocks sooner
								busy_val = wid(tim_q.wl) +
									(ctrl_q[CTRL_BC4MRS] ? CNT_W'(2) : CNT_W'(4));
								pden_val = busy_val + wid(tim_q.wr) +
									((op == OP_WRAP) ? CNT_W'(1) : CNT_W'(0));
								if (op == OP_WRAP) begin
									bank_open_d = 1'b0;
								end
							end
							OP_REF: begin
								pins_d.cmd = CMD_REF;
								pden_load = 1'b1;
								if (state_q == ST_PD) begin
									err_d = 1'b1;
								end
								if (refresh_in_pd_q) begin
									pden_val = CNT_W'(TXPDLL_CYC);
								end else begin
									pden_val = CNT_W'(ACT_PD_CYC);
								end
							end
							OP_MRS: begin
								pins_d.cmd = CMD_MRS;
								busy_load = 1'b1;
								busy_val = wid(tim_q.tmod);
								pden_load = 1'b1;
								pden_val = wid(tim_q.tmod);
							end
							OP_DLLRST: begin
								pins_d.cmd = CMD_MRS;
								dll_rst_need_d = 1'b0;
								busy_load = 1'b1;
								busy_val = wid(tim_q.tmod);
								pden_load = 1'b1;
								pden_val = wid(tim_q.tmod);
							end
							OP_PDE: begin
								// Entry waits for busy ops and delays
								if (state_q != ST_ACTIVE || busy_q || !pden_ok ||
								    (refresh_in_pd_q && !lock_ok)) begin
									pslverr_d = 1'b1;
								end else begin
									pins_d.cke = 1'b0;
									state_d = ST_PD;
									pd_time_d = '0;
									overdue_d = 1'b0;
									slow_d = !bank_open_q && !ctrl_q[CTRL_FAST];
									dll_rst_need_d = !lock_ok;
									cmd_load = 1'b1;
									cmd_val = CNT_W'(2);
									xp_load = 1'b1;
								end
							end
							OP_PDX: begin
								// After reset cke sits low in ACTIVE; exit is what wakes it
								if ((state_q != ST_PD &&
								     !(state_q == ST_ACTIVE && !pins_q.cke)) || !xp_ok) begin
									pslverr_d = 1'b1;
								end else begin
									pins_d.cke = 1'b1;
									state_d = ST_EXIT;
									refresh_in_pd_d = 1'b1;
									xp_load = 1'b1;
									cmd_load = 1'b1;
									cmd_val = CNT_W'(ACT_PD_CYC + 2);
									lock_load = slow_q;
								end
							end
							default: pslverr_d = 1'b1;
						endcase
						if (op != OP_REF && op != OP_PDX && op != OP_PDE) begin
							refresh_in_pd_d = 1'b0;
						end
					end
				end
				default: pslverr_d = 1'b1;
			endcase
		end

		if (rd_acc) begin
			unique case (paddr)
				REG_CTRL:   prdata_d = ctrl_q;
				REG_TIMING: prdata_d = 32'(tim_q);
				REG_CMD:    prdata_d = 32'h0000_0000;
				REG_STATUS: prdata_d = {24'h0, overdue_q, err_q, dll_rst_need_q,
				                        slow_q, bank_open_q, busy_q, state_q};
				default: begin
					prdata_d = 32'h0000_0000;
					pslverr_d = 1'b1;
				end
			endcase
		end
		// No self refresh hot unless an option is set
		if (ctrl_q[CTRL_HOT] && !ctrl_q[CTRL_AUTO_SR] && !ctrl_q[CTRL_SR_RANGE]) begin
			err_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_ACTIVE;
			ctrl_q <= CTRL_RST;
			tim_q <= timing_s'(TIMING_RST);
			pins_q <= '{cke: 1'b0, reset_n: 1'b0, cmd: CMD_NOP, a12: 1'b1};
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			busy_q <= 1'b0;
			bank_open_q <= 1'b0;
			dll_rst_need_q <= 1'b0;
			slow_q <= 1'b0;
			refresh_in_pd_q <= 1'b0;
			err_q <= 1'b0;
			pd_time_q <= '0;
			overdue_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			tim_q <= tim_d;
			pins_q <= pins_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			busy_q <= busy_d || busy_load;
			bank_open_q <= bank_open_d;
			dll_rst_need_q <= dll_rst_need_d;
			slow_q <= slow_d;
			refresh_in_pd_q <= refresh_in_pd_d;
			err_q <= err_d;
			pd_time_q <= pd_time_d;
			overdue_q <= overdue_d;
		end
	end

	// Outputs straight from flip-flops
	assign dram = pins_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign auto_self_refresh = ctrl_q[CTRL_AUTO_SR];
	assign self_refresh_temp_range = ctrl_q[CTRL_SR_RANGE];
	assign mr0_fast_exit = ctrl_q[CTRL_FAST];
endmodule

// ---- testbench/pd_ctrl_sva.sv ----
/* Pin timing checker for pd_ctrl.
   Assumes the TIMING register keeps its reset value. */
`timescale 1ns/1ps
module pd_ctrl_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins
	input wire pd_ctrl_pkg::dram_pins_s dram,
	input wire logic auto_self_refresh,
	input wire logic self_refresh_temp_range,
	input wire logic mr0_fast_exit
);
	import pd_ctrl_pkg::*;
	logic [7:0] gap_q, gap_d, up_q, up_d;
	logic [3:0] last_q, last_d;
	logic cke_q, ref_q, ref_d, open_q, open_d, slow_q, slow_d;
	// Lower bound per command; WR uses the fixed chop figure, WRAP looks like WR
	function automatic logic [7:0] need(input logic [3:0] c);
		case (c)
			CMD_RD: need = 8'h11;
			CMD_WR: need = 8'h0b;
			CMD_MRS: need = 8'h06;
			default: need = 8'h01;
		endcase
	endfunction
	// Saturating ages of the last command and the last exit
	always_comb begin
		gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
		up_d = (up_q == 8'hff) ? up_q : up_q + 8'h01;
		last_d = (dram.cmd != CMD_NOP) ? dram.cmd : last_q;
		ref_d = ref_q | (dram.cmd == CMD_REF);
		open_d = (dram.cmd == CMD_ACT) | (open_q & (dram.cmd != CMD_PRE));
		slow_d = (!dram.cke && cke_q) ? (!open_q && !mr0_fast_exit) : slow_q;
		if (dram.cmd != CMD_NOP) gap_d = 8'h01;
		if (dram.cke && !cke_q) begin
			up_d = 8'h01;
			ref_d = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{gap_q, up_q, last_q} <= {16'hffff, CMD_NOP};
			{cke_q, ref_q, open_q, slow_q} <= 4'h0;
		end else begin
			{gap_q, up_q, last_q} <= {gap_d, up_d, last_d};
			{cke_q, ref_q, open_q, slow_q} <= {dram.cke, ref_d, open_d, slow_d};
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mode_legal; !(auto_self_refresh && self_refresh_temp_range); endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("both sr options set");
	property p_entry_gap; $fell(dram.cke) |-> gap_q >= need(last_q); endproperty
	a_entry_gap: assert property (p_entry_gap) else $error("cke fell too soon");
	property p_ref_gap; $fell(dram.cke) && ref_q |-> up_q >= 8'h0a; endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("re-entry too soon");
	property p_quiet; $past(presetn) && !dram.cke |-> dram.cmd == CMD_NOP && dram.reset_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("command in power-down");
	property p_pd_min; $fell(dram.cke) |-> !dram.cke [*3]; endproperty
	a_pd_min: assert property (p_pd_min) else $error("power-down too short");
	property p_exit; $rose(dram.cke) |-> (dram.cmd == CMD_NOP) ##0 dram.cke [*3]; endproperty
	a_exit: assert property (p_exit) else $error("bad exit");
	property p_xp; dram.cmd != CMD_NOP |-> up_q >= 8'h03; endproperty
	a_xp: assert property (p_xp) else $error("command before exit delay");
	property p_xpdll; dram.cmd == CMD_RD && slow_q |-> up_q >= 8'h0a; endproperty
	a_xpdll: assert property (p_xpdll) else $error("read before dll delay");
endmodule
bind pd_ctrl pd_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .dram(dram),
	.auto_self_refresh(auto_self_refresh),
	.self_refresh_temp_range(self_refresh_temp_range), .mr0_fast_exit(mr0_fast_exit));

// ---- testbench/dram_pd_model.sv ----
/* Behavioural device: power-down state, DLL and termination mode.
   Assumes pins come from pd_ctrl on pclk; counts controller faults. */
`timescale 1ns/1ps
module dram_pd_model (
	// Clock and pins
	input wire logic pclk,
	input wire pd_ctrl_pkg::dram_pins_s dram,
	input wire logic auto_self_refresh,
	input wire logic self_refresh_temp_range,
	input wire logic mr0_fast_exit,
	// Device state
	output logic pd_q,
	output logic dll_on_q,
	output logic odt_async_q,
	output logic sr_auto,
	output logic sr_ext,
	output logic [7:0] viol_q
);
	import pd_ctrl_pkg::*;
	logic pd_d, dll_d, odt_d, open_q, open_d;
	logic [7:0] viol_d, cnt_q, cnt_d;
	assign sr_auto = auto_self_refresh;
	assign sr_ext = !auto_self_refresh && self_refresh_temp_range;
	// Faults are counted, not fatal, so the bench can judge them
	always_comb begin
		{pd_d, dll_d, odt_d, open_d, viol_d} = {pd_q, dll_on_q, odt_async_q, open_q, viol_q};
		cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
		if (!pd_q && !dram.cke) begin
			pd_d = 1'b1;
			dll_d = open_q | mr0_fast_exit;
			odt_d = !(open_q | mr0_fast_exit);
			viol_d = viol_q + {7'h0, dram.cmd != CMD_NOP};
		end else if (pd_q) begin
			viol_d = viol_q + {7'h0, dram.cmd != CMD_NOP};
			if (dram.cke) pd_d = 1'b0;
			if (dram.cke) cnt_d = 8'h00;
		end else begin
			open_d = (dram.cmd == CMD_ACT) | (open_q & (dram.cmd != CMD_PRE));
			if (cnt_q >= 8'(TXPDLL_CYC - 2)) {dll_d, odt_d} = 2'b10;
			viol_d = viol_q + {7'h0, dram.cmd == CMD_RD && !dll_on_q};
		end
		if (auto_self_refresh && self_refresh_temp_range) viol_d = viol_q + 8'h01;
	end
	// Reset pin clears everything at once, power-down included
	always_ff @(posedge pclk or negedge dram.reset_n) begin
		if (!dram.reset_n) begin
			{pd_q, dll_on_q, odt_async_q, open_q, viol_q, cnt_q} <= '0;
		end else begin
			{pd_q, dll_on_q, odt_async_q, open_q, viol_q, cnt_q} <=
				{pd_d, dll_d, odt_d, open_d, viol_d, cnt_d};
		end
	end
endmodule

// ---- testbench/pd_ctrl_tb_top.sv ----
/* Self-checking bench for pd_ctrl with the device model.
   Assumes TIMING keeps its reset value throughout. */
`timescale 1ns/1ps
module pd_ctrl_tb_top;
	import pd_ctrl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, cke_p;
	logic auto_self_refresh, self_refresh_temp_range, mr0_fast_exit;
	logic m_pd, m_dll, m_odt, m_sra, m_sre;
	logic [7:0] paddr, viol;
	logic [31:0] pwdata, prdata, rd_q;
	dram_pins_s dram;
	int n_errors, n_compared, cyc, cmd_cyc, fall_cyc, rise_cyc;
	pd_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dram(dram),
		.auto_self_refresh(auto_self_refresh),
		.self_refresh_temp_range(self_refresh_temp_range), .mr0_fast_exit(mr0_fast_exit));
	dram_pd_model u_dev (.pclk(pclk), .dram(dram), .auto_self_refresh(auto_self_refresh),
		.self_refresh_temp_range(self_refresh_temp_range),
		.mr0_fast_exit(mr0_fast_exit), .pd_q(m_pd), .dll_on_q(m_dll),
		.odt_async_q(m_odt), .sr_auto(m_sra), .sr_ext(m_sre), .viol_q(viol));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Edge stamps of commands and cke changes, as the device samples them
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		cke_p <= dram.cke;
		if (dram.cmd !== CMD_NOP) cmd_cyc <= cyc;
		if (cke_p === 1'b1 && dram.cke === 1'b0) fall_cyc <= cyc;
		if (cke_p === 1'b0 && dram.cke === 1'b1) rise_cyc <= cyc;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic bad(input string m);
		n_errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) bad(m);
	endtask
	task automatic at_least(input int g, input int e, input string m);
		n_compared++;
		if (g < e) bad(m);
	endtask
	task automatic close_out();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One APB transfer; the request holds until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd_q = prdata;
		err_q = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
		if (pready_seen_fail(n)) begin
			bad("no pready");
			close_out();
		end
	endtask
	// A wait that used up its bound ends the run
	function automatic bit pready_seen_fail(input int n);
		return n >= 50;
	endfunction
	// Commands may be refused while a delay runs, so retry a bounded number of times
	task automatic order(input logic [3:0] op);
		int k;
		k = 0;
		do begin
			apb(1'b1, REG_CMD, {28'h0, op});
			k++;
		end while (err_q !== 1'b0 && k < 40);
		if (err_q !== 1'b0) begin
			bad("order refused");
			close_out();
		end
	endtask
	task automatic wait_cke(input logic v);
		int k;
		k = 0;
		while (dram.cke !== v && k < 100) begin
			@(posedge pclk);
			k++;
		end
		if (dram.cke !== v) begin
			bad("cke stuck");
			close_out();
		end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, REG_CTRL, 32'h0);
		cmp(rd_q, CTRL_RST, "ctrl reset");
		apb(1'b0, REG_TIMING, 32'h0);
		cmp(rd_q, TIMING_RST, "timing reset");
		apb(1'b0, 8'h10, 32'h0);
		cmp({31'h0, err_q}, 32'h1, "unmapped");
	endtask
	task automatic t_mode();
		apb(1'b1, REG_CTRL, 32'h3);
		cmp({29'h0, err_q, auto_self_refresh, self_refresh_temp_range}, 32'h4, "both bits");
		apb(1'b1, REG_CTRL, 32'h1);
		cmp({29'h0, auto_self_refresh, self_refresh_temp_range, m_sra}, 32'h5, "auto mode");
		apb(1'b1, REG_CTRL, 32'h6);
		cmp({29'h0, self_refresh_temp_range, mr0_fast_exit, m_sre}, 32'h7, "ext mode");
	endtask
	// Each command then entry; delays use the TIMING reset figures
	task automatic t_entry();
		logic [3:0] ops [7];
		int lim [7];
		logic opn [7];
		ops = '{OP_ACT, OP_RD, OP_WR, OP_WRAP, OP_PRE, OP_REF, OP_MRS};
		lim = '{1, 17, 13, 14, 1, 1, 6};
		opn = '{1, 1, 1, 0, 0, 0, 0};
		for (int i = 0; i < 7; i++) begin
			order(ops[i]);
			order(OP_PDE);
			wait_cke(1'b0);
			at_least(fall_cyc - cmd_cyc, lim[i], "entry early");
			apb(1'b0, REG_STATUS, 32'h0);
			cmp(rd_q & 32'h0b, {28'h0, opn[i], 3'h1}, "pd kind");
			cmp({31'h0, m_pd}, 32'h1, "dev pd");
			order(OP_PDX);
			wait_cke(1'b1);
		end
	endtask
	task automatic t_slow();
		apb(1'b1, REG_CTRL, 32'h0);
		order(OP_PDE);
		wait_cke(1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp({30'h0, m_dll, m_odt}, 32'h1, "slow dll");
		order(OP_PDX);
		wait_cke(1'b1);
		apb(1'b1, REG_CMD, {28'h0, OP_RD});
		cmp({31'h0, err_q}, 32'h1, "early read");
		order(OP_REF);
		order(OP_PDE);
		wait_cke(1'b0);
		at_least(fall_cyc - rise_cyc, TXPDLL_CYC, "reentry early");
		order(OP_PDX);
		wait_cke(1'b1);
		cmp({24'h0, viol}, 32'h0, "dev faults");
	endtask
	// Hot case without an option flags; hot halves the residency limit
	task automatic t_hot();
		apb(1'b1, REG_CTRL, 32'h8);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp(rd_q & 32'h40, 32'h40, "hot without option");
		apb(1'b1, REG_CTRL, 32'h9);
		order(OP_PDE);
		wait_cke(1'b0);
		repeat (7100) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp(rd_q & 32'h80, 32'h80, "hot overdue");
		order(OP_PDX);
		wait_cke(1'b1);
	endtask
	task automatic t_reset();
		order(OP_PDE);
		wait_cke(1'b0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp({30'h0, dram.reset_n, m_pd}, 32'h0, "reset in pd");
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		cmp(rd_q & 32'h3, 32'h0, "state after reset");
	endtask
	// Watchdog
	initial begin
		repeat (40000) @(posedge pclk);
		bad("timeout");
		close_out();
	end
	// Main sequence
	initial begin
		{n_errors, n_compared, cyc, cmd_cyc, fall_cyc, rise_cyc} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_mode();
		order(OP_PDX);
		wait_cke(1'b1);
		t_entry();
		t_slow();
		t_hot();
		t_reset();
		close_out();
	end
endmodule
